// ### rxm_pkg.sv
// Constants, types and register map of the receive core-to-fabric mux.
// Assumes a single 25 MHz register clock and inputs from other domains.
package rxm_pkg;

  // ==========================================================
  // Sizes
  localparam int NUM_CH = 8;
  localparam int CH_W = 40;
  localparam int WORD_W = 32;
  localparam int SLICE_W = 20;
  localparam int NUM_BUNDLES = 4;
  localparam int WIDE_W = 140;
  localparam int UP_LSB = 32;

  // ==========================================================
  // Bit positions of the fixed upper byte, relative to bit 32
  localparam int UP_PAIR_LOST = 7;
  localparam int UP_OCTET_LOST = 7;
  localparam int UP_WIDE_DISCARD = 7;
  localparam int UP_QUAD_LOST = 6;
  localparam int UP_DISCARD = 6;
  localparam int UP_BACKPRESSURE = 6;
  localparam int UP_WIDE_FIRST = 6;
  localparam int UP_FIRST = 5;
  localparam int UP_BEGIN_GOOD = 5;
  localparam int UP_FRAME = 4;
  localparam int UP_OOF = 3;
  localparam int UP_SPE = 2;
  localparam int UP_CELL_PERR = 1;
  localparam int UP_B1 = 0;

  // Channel indices AA..BD.
  localparam int CH_AD = 3;
  localparam int CH_BB = 5;

  // ==========================================================
  // Register map
  localparam int ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFF_MODE = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_CLEAR = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_ENABLE = 5'h0c;
  localparam logic [ADDR_W-1:0] OFF_STATE = 5'h10;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int EV_W = 4;
  localparam int EV_ALIGN = 0;
  localparam int EV_B1 = 1;
  localparam int EV_CELL_PERR = 2;
  localparam int EV_DISCARD = 3;

  typedef enum logic [1:0] {
    RXM_SONET = 2'h0,
    RXM_TWO_LINK = 2'h1,
    RXM_EIGHT_LINK = 2'h2,
    RXM_IDLE = 2'h3
  } rxm_mode_type;

  localparam rxm_mode_type MODE_RESET = RXM_IDLE;

  // ==========================================================
  // Receive results coming from the core side
  typedef struct packed {
    logic [NUM_CH-1:0][WORD_W-1:0] sonet_rx_word;
    logic [NUM_CH-1:0] frame_pulse;
    logic [NUM_CH-1:0] out_of_frame;
    logic [NUM_CH-1:0] payload_envelope;
    logic [NUM_CH-1:0] section_parity_err;
    logic [NUM_BUNDLES-1:0][CH_W-1:0] two_link_bundle_data;
    logic [NUM_BUNDLES-1:0] bundle_cell_discard;
    logic [NUM_BUNDLES-1:0] bundle_cell_first_word;
    logic [NUM_BUNDLES-1:0] bundle_cell_parity_err;
    logic [NUM_BUNDLES-1:0] bundle_cell_begin_good;
    logic [WIDE_W-1:0] eight_link_bundle_data;
    logic wide_bundle_cell_discard;
    logic wide_bundle_cell_first_word;
    logic wide_bundle_cell_parity_err;
    logic wide_bundle_backpressure;
    logic [NUM_BUNDLES-1:0] pair_align_lost;
    logic [1:0] quad_align_lost;
    logic octet_align_lost;
  } rxm_core_in_type;

endpackage

// ### rxm_rx_mux.sv
// Receive multiplexer from the serial core onto eight 40-bit fabric buses,
// with an AXI4-Lite register slave and one level interrupt.
// Assumes core results and clocks are asynchronous to aclk.
`timescale 1ns/1ps
`default_nettype none

module rxm_rx_mux
  import rxm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire rxm_core_in_type core_in,
  input wire logic [NUM_CH-1:0] serdes_rx_clock,
  input wire logic fifo_read_clock,
  output logic [NUM_CH-1:0] recovered_rx_clock,
  output logic [NUM_CH-1:0][CH_W-1:0] rx_channel_bus,
  output logic irq,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ==========================================================
  // Input synchronisers
  // The whole result set crosses on two flops. A multi-bit word can tear
  // across the crossing; it is only latched on a read clock edge that the
  // fabric keeps slow against aclk, so the word has settled by then.
  rxm_core_in_type in_meta;
  rxm_core_in_type in_sync;
  logic [NUM_CH-1:0] rclk_meta;
  logic [NUM_CH-1:0] rclk_sync;
  logic [1:0] rd_clk_sync;
  logic rd_clk_prev;

  always_ff @(posedge aclk) begin
    in_meta <= core_in;
    in_sync <= in_meta;
    rclk_meta <= serdes_rx_clock;
    rclk_sync <= rclk_meta;
    rd_clk_sync <= {rd_clk_sync[0], fifo_read_clock};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_clk_prev <= 1'b0;
    end else begin
      rd_clk_prev <= rd_clk_sync[1];
    end
  end

  // The read clock from the fabric paces every update of the buses.
  wire rd_clk_rise = rd_clk_sync[1] & ~rd_clk_prev;

  // ==========================================================
  // Registers
  rxm_mode_type mode;
  logic [EV_W-1:0] status;
  logic [EV_W-1:0] enable;
  logic [NUM_BUNDLES+2:0] lost_prev;

  // ==========================================================
  // Per-channel mapping
  logic [NUM_CH-1:0][CH_W-1:0] next_bus;

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CH; ch++) begin : g_ch
      localparam int BUN = ch / 2;
      localparam bit FIRST = (ch % 2) == 0;
      wire [7:0] upper;
      wire [WORD_W-1:0] two_word;
      wire [WORD_W-1:0] eight_word;
      wire [WORD_W-1:0] low_word;

      if (FIRST) begin : g_first
        assign two_word = {12'h000,
          in_sync.two_link_bundle_data[BUN][CH_W-1:SLICE_W]};
      end else begin : g_second
        assign two_word = {12'h000,
          in_sync.two_link_bundle_data[BUN][SLICE_W-1:0]};
      end

      if (ch == 0) begin : g_no_slice
        assign eight_word = 32'h0000_0000;
      end else begin : g_slice
        assign eight_word = {12'h000,
          in_sync.eight_link_bundle_data[(NUM_CH-ch)*SLICE_W-1 -: SLICE_W]};
      end

      assign low_word =
        (mode == RXM_SONET) ? in_sync.sonet_rx_word[ch] :
        (mode == RXM_TWO_LINK) ? two_word :
        (mode == RXM_EIGHT_LINK) ? eight_word :
        32'h0000_0000;

      // The upper byte is wired the same way in every mode.
      assign upper[UP_FRAME] = in_sync.frame_pulse[ch];
      assign upper[UP_OOF] = in_sync.out_of_frame[ch];
      assign upper[UP_SPE] = in_sync.payload_envelope[ch];
      assign upper[UP_B1] = in_sync.section_parity_err[ch];

      if (FIRST) begin : g_first_up
        assign upper[UP_PAIR_LOST] = in_sync.pair_align_lost[BUN];
        assign upper[UP_DISCARD] = in_sync.bundle_cell_discard[BUN];
        assign upper[UP_FIRST] = in_sync.bundle_cell_first_word[BUN];
        assign upper[UP_CELL_PERR] =
          in_sync.bundle_cell_parity_err[BUN];
      end else begin : g_second_up
        assign upper[UP_BEGIN_GOOD] =
          in_sync.bundle_cell_begin_good[BUN];
        if (ch == CH_AD) begin : g_wide
          assign upper[UP_WIDE_DISCARD] = in_sync.wide_bundle_cell_discard;
          assign upper[UP_WIDE_FIRST] = in_sync.wide_bundle_cell_first_word;
          assign upper[UP_CELL_PERR] =
            in_sync.wide_bundle_cell_parity_err;
        end else if (ch == CH_BB) begin : g_octet
          assign upper[UP_OCTET_LOST] = in_sync.octet_align_lost;
          assign upper[UP_BACKPRESSURE] = in_sync.wide_bundle_backpressure;
          assign upper[UP_CELL_PERR] = 1'b0;
        end else begin : g_quad
          assign upper[UP_PAIR_LOST] = 1'b0;
          assign upper[UP_QUAD_LOST] = in_sync.quad_align_lost[BUN/2];
          assign upper[UP_CELL_PERR] = 1'b0;
        end
      end

      assign next_bus[ch] = {upper, low_word};
    end
  endgenerate

  // Outputs are registered so the fabric sees no glitching mux.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_channel_bus <= '0;
    end else if (rd_clk_rise) begin
      rx_channel_bus <= next_bus;
    end
  end

  // ==========================================================
  // Recovered clocks
  // Forwarded through the synchronisers; the copy is only as fine as
  // aclk resolves it, so a fast clock arrives aliased.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      recovered_rx_clock <= '0;
    end else begin
      recovered_rx_clock <= rclk_sync;
    end
  end

  // ==========================================================
  // Events
  wire [NUM_BUNDLES+2:0] lost_now = {in_sync.octet_align_lost,
    in_sync.quad_align_lost, in_sync.pair_align_lost};
  wire [EV_W-1:0] events;
  assign events[EV_ALIGN] = |(lost_now & ~lost_prev);
  assign events[EV_B1] = |in_sync.section_parity_err;
  assign events[EV_CELL_PERR] = (|in_sync.bundle_cell_parity_err) |
    in_sync.wide_bundle_cell_parity_err;
  assign events[EV_DISCARD] = (|in_sync.bundle_cell_discard) |
    in_sync.wide_bundle_cell_discard;

  // ==========================================================
  // AXI4-Lite write path
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire aw_have = aw_held | aw_take;
  wire w_have = w_held | w_take;
  wire wr_fire = aw_have & w_have & ~s_axi_bvalid;
  wire [ADDR_W-1:0] wr_addr = aw_held ? aw_addr : s_axi_awaddr;
  wire [31:0] wr_data = w_held ? w_data : s_axi_wdata;
  wire [3:0] wr_strb = w_held ? w_strb : s_axi_wstrb;
  wire wr_mode = wr_fire & (wr_addr == OFF_MODE) & wr_strb[0];
  wire wr_clear = wr_fire & (wr_addr == OFF_CLEAR) & wr_strb[0];
  wire wr_enable = wr_fire & (wr_addr == OFF_ENABLE) & wr_strb[0];
  wire wr_known = (wr_addr == OFF_MODE) | (wr_addr == OFF_CLEAR) |
    (wr_addr == OFF_ENABLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= '0;
      w_strb <= '0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else begin
        if (aw_take) begin
          aw_held <= 1'b1;
          aw_addr <= s_axi_awaddr;
        end
        if (w_take) begin
          w_held <= 1'b1;
          w_data <= s_axi_wdata;
          w_strb <= s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Control and interrupt registers
  // A new event in the cycle of a clear keeps its bit set.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode <= MODE_RESET;
      enable <= '0;
      status <= '0;
      lost_prev <= '0;
    end else begin
      lost_prev <= lost_now;
      if (wr_mode) begin
        mode <= rxm_mode_type'(wr_data[1:0]);
      end
      if (wr_enable) begin
        enable <= wr_data[EV_W-1:0];
      end
      status <= (status & ~(wr_clear ? wr_data[EV_W-1:0] : '0)) | events;
    end
  end

  assign irq = |(status & enable);

  // ==========================================================
  // AXI4-Lite read path
  wire [31:0] rd_word =
    (s_axi_araddr == OFF_MODE) ? {30'h0, mode} :
    (s_axi_araddr == OFF_STATUS) ? {28'h0, status} :
    (s_axi_araddr == OFF_ENABLE) ? {28'h0, enable} :
    (s_axi_araddr == OFF_STATE) ? {25'h0, lost_now} :
    32'h0000_0000;
  wire rd_known = (s_axi_araddr == OFF_MODE) |
    (s_axi_araddr == OFF_STATUS) | (s_axi_araddr == OFF_CLEAR) |
    (s_axi_araddr == OFF_ENABLE) | (s_axi_araddr == OFF_STATE);

  assign s_axi_arready = ~s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ### rxm_rx_mux_monitor.sv
// Port checker for the receive mux, bound to every instance.
// Assumes a single clock domain, aclk, with synchronous reset aresetn.
`timescale 1ns/1ps
`default_nettype none
module rxm_rx_mux_monitor
  import rxm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [NUM_CH-1:0] serdes_rx_clock,
  input wire logic fifo_read_clock,
  input wire logic [NUM_CH-1:0] recovered_rx_clock,
  input wire logic [NUM_CH-1:0][CH_W-1:0] rx_channel_bus,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // ==========================================================
  // Properties
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // The pipelines must hold post-reset values before history is trusted.
  property p_rclk;
    $past(aresetn, 3) |-> recovered_rx_clock == $past(serdes_rx_clock, 3);
  endproperty
  a_rclk: assert property (p_rclk) else $error("clock copy");
  property p_bus_hold;
    $past(aresetn) && $past(aresetn, 4) && !$stable(rx_channel_bus)
      |-> $past(fifo_read_clock, 3) && !$past(fifo_read_clock, 4);
  endproperty
  a_bus_hold: assert property (p_bus_hold) else $error("bus moved");
  property p_unused_low;
    !rx_channel_bus[1][39] && !rx_channel_bus[7][39]
      && !rx_channel_bus[1][33] && !rx_channel_bus[7][33]
      && !rx_channel_bus[5][33];
  endproperty
  a_unused_low: assert property (p_unused_low) else $error("spare");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  property p_ar_block;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_block: assert property (p_ar_block) else $error("read overtaken");
  property p_aw_block;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_aw_block: assert property (p_aw_block) else $error("write overtaken");
  property p_r_answer;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_r_answer: assert property (p_r_answer) else $error("read answer late");
endmodule
bind rxm_rx_mux rxm_rx_mux_monitor mon (
  .aclk, .aresetn, .serdes_rx_clock, .fifo_read_clock, .recovered_rx_clock,
  .rx_channel_bus, .s_axi_awready, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready
);
`default_nettype wire

// ### rxm_fabric_model.sv
// Fabric side model: makes the alignment FIFO read clock.
// Assumes the bench may stall it through run.
`timescale 1ns/1ps
`default_nettype none
module rxm_fabric_model #(
  parameter realtime HALF_NS = 160.0
) (
  input wire logic run,
  output logic fifo_read_clock
);
  // ==========================================================
  // Read clock
  // Free-running from the fixed HALF_NS, not locked to the write side; phase is arbitrary.
  initial begin
    fifo_read_clock = 1'h0;
    #7;
    forever begin
      #(HALF_NS);
      if (run) fifo_read_clock = ~fifo_read_clock;
    end
  end
endmodule
`default_nettype wire

// ### rxm_rx_mux_tb.sv
// Self-checking bench for the receive mux: register tasks and bus checks.
// Assumes the fabric model supplies the alignment FIFO read clock.
`timescale 1ns/1ps
`default_nettype none
module rxm_rx_mux_tb
  import rxm_pkg::*;
;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic run = 1'h1;
  rxm_core_in_type core_in = '0;
  logic [NUM_CH-1:0] serdes_rx_clock = '0;
  logic [NUM_CH-1:0] recovered_rx_clock;
  logic [NUM_CH-1:0][CH_W-1:0] rx_channel_bus, expb;
  wire fifo_read_clock;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, irq;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [639:0] pat;
  int err_total = 0, samples_checked = 0, i, m;
  rxm_fabric_model fab (.run, .fifo_read_clock);
  rxm_rx_mux dut (
    .aclk, .aresetn, .core_in, .serdes_rx_clock, .fifo_read_clock,
    .recovered_rx_clock, .rx_channel_bus, .irq, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  always #20 aclk = ~aclk;
  always @(posedge aclk) serdes_rx_clock <= serdes_rx_clock + 8'h1;
  // ==========================================================
  // Tasks
  task automatic check(input string what, input logic [39:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic tmo(input int n);
    if (n >= 50) begin
      err_total++;
      complete_run();
    end
  endtask
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready === 1'h1) s_axi_awvalid <= 1'h0;
      if (s_axi_wready === 1'h1) s_axi_wvalid <= 1'h0;
      if (s_axi_bvalid === 1'h1) break;
    end
    s_axi_bready <= 1'h0;
    tmo(n);
    check("bresp", s_axi_bresp, er);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] e,
                    input logic [1:0] er, input string what);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready === 1'h1) s_axi_arvalid <= 1'h0;
      if (s_axi_rvalid === 1'h1) break;
    end
    s_axi_rready <= 1'h0;
    tmo(n);
    check(what, s_axi_rdata, e);
    check(what, s_axi_rresp, er);
  endtask
  // The bus has no strobe, so wait for the expected value under a bound.
  task automatic settle(input string what);
    for (i = 0; i < 50 && rx_channel_bus !== expb; i++) @(posedge aclk);
    tmo(i);
    for (i = 0; i < NUM_CH; i++) check(what, rx_channel_bus[i], expb[i]);
  endtask
  function automatic logic [NUM_CH-1:0][CH_W-1:0] model(input logic [1:0] md);
    logic [NUM_CH-1:0][CH_W-1:0] e;
    int c, b;
    e = '0;
    for (c = 0; c < NUM_CH; c++) begin
      b = c / 2;
      if (md == 2'h0) e[c][31:0] = core_in.sonet_rx_word[c];
      if (md == 2'h1) e[c][19:0] = c[0] ?
        core_in.two_link_bundle_data[b][19:0] :
        core_in.two_link_bundle_data[b][39:20];
      if (md == 2'h2 && c > 0)
        e[c][19:0] = core_in.eight_link_bundle_data[(7 - c) * 20 +: 20];
      e[c][36:34] = {core_in.frame_pulse[c], core_in.out_of_frame[c],
                     core_in.payload_envelope[c]};
      e[c][32] = core_in.section_parity_err[c];
      if (!c[0]) e[c][39:37] = {core_in.pair_align_lost[b],
        core_in.bundle_cell_discard[b], core_in.bundle_cell_first_word[b]};
      if (!c[0]) e[c][33] = core_in.bundle_cell_parity_err[b];
      if (c[0]) e[c][37] = core_in.bundle_cell_begin_good[b];
    end
    e[1][38] = core_in.quad_align_lost[0];
    e[7][38] = core_in.quad_align_lost[1];
    e[3][39:38] = {core_in.wide_bundle_cell_discard,
                   core_in.wide_bundle_cell_first_word};
    e[3][33] = core_in.wide_bundle_cell_parity_err;
    e[5][39:38] = {core_in.octet_align_lost,
                   core_in.wide_bundle_backpressure};
    return e;
  endfunction
  // ==========================================================
  // Sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    rd(OFF_MODE, 32'h3, RESP_OKAY, "mode");
    rd(5'h14, 32'h0, RESP_SLVERR, "unmapped");
    wr(5'h18, 32'h1, RESP_SLVERR);
    expb = '0;
    settle("reset bus");
    $display("register test done");
    for (m = 0; m < 4; m++) begin
      pat = {20{32'h5a3c_96e1 + m * 32'h2468_ace1}};
      core_in <= pat[$bits(rxm_core_in_type)-1:0];
      wr(OFF_MODE, m, RESP_OKAY);
      expb = model(m[1:0]);
      settle("bus");
      rd(OFF_STATE, {25'h0, core_in.octet_align_lost, core_in.quad_align_lost,
         core_in.pair_align_lost}, RESP_OKAY, "state");
      $display("mode %0d test done", m);
    end
    run <= 1'h0;
    core_in <= ~core_in;
    for (i = 0; i < 20; i++) @(posedge aclk);
    check("stalled bus", rx_channel_bus[2], expb[2]);
    run <= 1'h1;
    expb = model(2'h3);
    settle("resumed bus");
    $display("stall test done");
    core_in <= '0;
    wr(OFF_ENABLE, 32'h2, RESP_OKAY);
    wr(OFF_CLEAR, 32'hf, RESP_OKAY);
    rd(OFF_STATUS, 32'h0, RESP_OKAY, "status clear");
    check("irq idle", irq, 1'h0);
    core_in.section_parity_err[2] <= 1'h1;
    for (i = 0; i < 50 && irq !== 1'h1; i++) @(posedge aclk);
    tmo(i);
    check("irq raised", irq, 1'h1);
    core_in.section_parity_err[2] <= 1'h0;
    rd(OFF_STATUS, 32'h2, RESP_OKAY, "status set");
    wr(OFF_ENABLE, 32'h0, RESP_OKAY);
    check("irq masked", irq, 1'h0);
    // A write without byte lane 0 must leave the register alone.
    s_axi_wstrb <= 4'he;
    wr(OFF_ENABLE, 32'hf, RESP_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(OFF_ENABLE, 32'h0, RESP_OKAY, "enable lane off");
    wr(OFF_CLEAR, 32'h2, RESP_OKAY);
    rd(OFF_STATUS, 32'h0, RESP_OKAY, "status after clear");
    rd(OFF_CLEAR, 32'h0, RESP_OKAY, "clear reads");
    // Align-lost rise, cell parity and cell discard each set their bit.
    core_in.pair_align_lost[1] <= 1'h1;
    core_in.wide_bundle_cell_parity_err <= 1'h1;
    core_in.bundle_cell_discard[3] <= 1'h1;
    repeat (4) @(posedge aclk);
    rd(OFF_STATUS, 32'hd, RESP_OKAY, "status events");
    $display("interrupt test done");
    complete_run();
  end
endmodule
`default_nettype wire
